// ==== fsp_pkg.sv ====
// Constants shared by the sector protection block
package fsp_pkg;
  // Command opcodes
  localparam logic [7:0] OPC_WREN = 8'h06;
  localparam logic [7:0] OPC_WRDI = 8'h04;
  localparam logic [7:0] OPC_PROT = 8'h36;
  localparam logic [7:0] OPC_UNPROT = 8'h39;
  localparam logic [7:0] OPC_WRSR_DEF = 8'h01;
  // Status write data fields
  localparam int SR_LOCK_POS = 7;
  localparam int SR_GLOB_HI = 5;
  localparam int SR_GLOB_LO = 2;
  localparam logic [3:0] SR_GLOB_ONES = 4'hf;
  localparam logic [3:0] SR_GLOB_ZEROS = 4'h0;
  // Sector geometry and address framing
  localparam int ADDR_W = 24;
  localparam int NUM_SECT = 4;
  localparam int SECT_IDX_W = 2;
  localparam int SECT_LSB_DEF = 16;
  localparam logic [1:0] ADDR_LAST = 2'h2;
  // Reset values
  localparam logic [NUM_SECT-1:0] PROT_RST = 4'hf;
  localparam logic LATCH_RST = 1'b0;
  localparam logic LOCK_RST = 1'b0;
  // Main sequencer states
  typedef enum logic [1:0] {ST_OPC, ST_ADDR, ST_WSR, ST_IGNORE} fsp_state_e;
endpackage : fsp_pkg

// ==== fsp_spi_rx.sv ====
// Serial pin synchroniser and byte assembler
`timescale 1ns/1ps
module fsp_spi_rx
  import fsp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  input wire logic wp_n_in,
  output logic byte_stb_out,
  output logic [7:0] byte_out,
  output logic frame_end_out,
  output logic aligned_out,
  output logic wp_n_out
);
  typedef struct packed {
    logic sck_m;
    logic sck_s;
    logic sck_d;
    logic cs_m;
    logic cs_s;
    logic cs_d;
    logic si_m;
    logic si_s;
    logic wp_m;
    logic wp_s;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic stb;
    logic [7:0] dat;
    logic fend;
    logic algn;
  } fsp_rx_s;

  fsp_rx_s r_r;
  fsp_rx_s r_nxt;

  // Two-stage sync, rising clock edge sampling, byte and frame-end strobes
  always_comb
  begin
    r_nxt = r_r;
    r_nxt.sck_m = sck_in;
    r_nxt.sck_s = r_r.sck_m;
    r_nxt.sck_d = r_r.sck_s;
    r_nxt.cs_m = cs_n_in;
    r_nxt.cs_s = r_r.cs_m;
    r_nxt.cs_d = r_r.cs_s;
    r_nxt.si_m = si_in;
    r_nxt.si_s = r_r.si_m;
    r_nxt.wp_m = wp_n_in;
    r_nxt.wp_s = r_r.wp_m;
    r_nxt.stb = 1'b0;
    r_nxt.fend = 1'b0;
    if (r_r.cs_s)
    begin
      r_nxt.cnt = 3'h0;
    end
    else if (r_r.sck_s && !r_r.sck_d)
    begin
      r_nxt.sh = {r_r.sh[6:0], r_r.si_s};
      r_nxt.cnt = r_r.cnt + 3'h1;
      if (r_r.cnt == 3'h7)
      begin
        r_nxt.stb = 1'b1;
        r_nxt.dat = {r_r.sh[6:0], r_r.si_s};
      end
    end
    // Frame ends on chip select release; note whether it fell on a byte edge
    if (r_r.cs_s && !r_r.cs_d)
    begin
      r_nxt.fend = 1'b1;
      r_nxt.algn = (r_r.cnt == 3'h0);
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      r_r <= '0;
      r_r.cs_m <= 1'b1;
      r_r.cs_s <= 1'b1;
      r_r.cs_d <= 1'b1;
      r_r.wp_m <= 1'b1;
      r_r.wp_s <= 1'b1;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  assign byte_stb_out = r_r.stb;
  assign byte_out = r_r.dat;
  assign frame_end_out = r_r.fend;
  assign aligned_out = r_r.algn;
  assign wp_n_out = r_r.wp_s;
endmodule : fsp_spi_rx

// ==== fsp_sector_protect.sv ====
// Sector protection flags with sector and global protect commands
// What this block does
// - One flag per sector, all set at reset
// - Program/erase allowed only in unprotected sectors
// - Protect: opcode 36h, three address bytes, rest ignored
// - Protect sets addressed flag, clears write latch
// - Short address or misaligned end aborts, clears latch
// - Locked: protect ignored, latch cleared at release
// - Unprotect: opcode 39h clears addressed flag, latch
// - Locked: unprotect ignored, latch cleared at release
// - Status write bits 5..2 ones, lock clear: protect all
// - Status write bits 5..2 zeros, lock clear: unprotect all
// - Sector commands still work after global changes
// - Status write may modify the lock bit
// - Pin low with lock set freezes the flags and the lock bit
// - Only bit 7 stored; bits 5..2 decoded
// - Opcode 06h on byte boundary sets latch
// - Sector commands need the write latch set
`timescale 1ns/1ps
module fsp_sector_protect
  import fsp_pkg::*;
#(
  parameter int SECT_LSB = SECT_LSB_DEF,
  parameter logic [7:0] WRSR_OPC = OPC_WRSR_DEF
)
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic spi_sck_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_si_in,
  input wire logic wp_n_in,
  input wire logic [ADDR_W-1:0] pe_addr_in,
  input wire logic pe_valid_in,
  output logic [NUM_SECT-1:0] sector_prot_out,
  output logic write_enable_latch_out,
  output logic protection_lock_bit_out,
  output logic pe_allow_out
);
  typedef struct packed {
    fsp_state_e st;
    logic [7:0] opc;
    logic [ADDR_W-1:0] addr;
    logic [7:0] sr;
    logic [1:0] nb;
    logic got;
    logic full;
    logic wlat;
    logic lock;
    logic [NUM_SECT-1:0] prot;
    logic allow;
  } fsp_main_s;

  fsp_main_s r_r;
  fsp_main_s r_nxt;
  logic [1:0] rst_q_r;
  logic rst_n;
  logic byte_stb;
  logic [7:0] byte_data;
  logic frame_end;
  logic aligned;
  logic wp_n_s;
  logic hard_lock;
  logic sect_cmd;
  logic sect_ok;
  logic do_prot;
  logic do_unprot;
  logic do_wsr;
  logic [3:0] glob_bits;

  // Sector index from a byte address
  function automatic logic [SECT_IDX_W-1:0] sector_of(input logic [ADDR_W-1:0] a);
    sector_of = a[SECT_LSB +: SECT_IDX_W];
  endfunction : sector_of

  // Reset release through two flip-flops
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rst_q_r <= 2'h0;
    end
    else
    begin
      rst_q_r <= {rst_q_r[0], 1'b1};
    end
  end
  assign rst_n = rst_q_r[1];

  fsp_spi_rx u_rx (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .sck_in(spi_sck_in),
    .cs_n_in(spi_cs_n_in),
    .si_in(spi_si_in),
    .wp_n_in(wp_n_in),
    .byte_stb_out(byte_stb),
    .byte_out(byte_data),
    .frame_end_out(frame_end),
    .aligned_out(aligned),
    .wp_n_out(wp_n_s)
  );

  // Command qualification at chip select release
  assign hard_lock = !wp_n_s && r_r.lock;
  assign sect_cmd = (r_r.opc == OPC_PROT) || (r_r.opc == OPC_UNPROT);
  assign sect_ok = frame_end && r_r.got && sect_cmd && r_r.wlat && r_r.full && aligned
    && !r_r.lock;
  assign do_prot = sect_ok && (r_r.opc == OPC_PROT);
  assign do_unprot = sect_ok && (r_r.opc == OPC_UNPROT);
  assign do_wsr = frame_end && r_r.got && (r_r.opc == WRSR_OPC) && r_r.wlat && r_r.full && aligned
    && !hard_lock;
  assign glob_bits = r_r.sr[SR_GLOB_HI:SR_GLOB_LO];

  // Byte decode, command execution and program/erase gate
  always_comb
  begin
    r_nxt = r_r;
    r_nxt.allow = pe_valid_in && !r_r.prot[sector_of(pe_addr_in)];
    if (byte_stb)
    begin
      unique case (r_r.st)
        ST_OPC:
        begin
          r_nxt.opc = byte_data;
          r_nxt.got = 1'b1;
          r_nxt.nb = 2'h0;
          if ((byte_data == OPC_PROT) || (byte_data == OPC_UNPROT))
          begin
            r_nxt.st = ST_ADDR;
          end
          else if (byte_data == WRSR_OPC)
          begin
            r_nxt.st = ST_WSR;
          end
          else
          begin
            r_nxt.st = ST_IGNORE;
          end
        end
        ST_ADDR:
        begin
          r_nxt.addr = {r_r.addr[ADDR_W-9:0], byte_data};
          r_nxt.nb = r_r.nb + 2'h1;
          if (r_r.nb == ADDR_LAST)
          begin
            r_nxt.full = 1'b1;
            r_nxt.st = ST_IGNORE;
          end
        end
        ST_WSR:
        begin
          r_nxt.sr = byte_data;
          r_nxt.full = 1'b1;
          r_nxt.st = ST_IGNORE;
        end
        ST_IGNORE:
        begin
          r_nxt.st = ST_IGNORE;
        end
      endcase
    end
    if (frame_end)
    begin
      if (r_r.got && aligned && (r_r.opc == OPC_WREN))
      begin
        r_nxt.wlat = 1'b1;
      end
      else if (r_r.got && aligned && (r_r.opc == OPC_WRDI))
      begin
        r_nxt.wlat = 1'b0;
      end
      else if (r_r.got && sect_cmd)
      begin
        r_nxt.wlat = 1'b0;
        if (do_prot)
        begin
          r_nxt.prot[sector_of(r_r.addr)] = 1'b1;
        end
        if (do_unprot)
        begin
          r_nxt.prot[sector_of(r_r.addr)] = 1'b0;
        end
      end
      else if (r_r.got && (r_r.opc == WRSR_OPC) && r_r.wlat)
      begin
        r_nxt.wlat = 1'b0;
        if (do_wsr)
        begin
          r_nxt.lock = r_r.sr[SR_LOCK_POS];
          if (!r_r.lock && (glob_bits == SR_GLOB_ONES))
          begin
            r_nxt.prot = '1;
          end
          else if (!r_r.lock && (glob_bits == SR_GLOB_ZEROS))
          begin
            r_nxt.prot = '0;
          end
        end
      end
      r_nxt.st = ST_OPC;
      r_nxt.got = 1'b0;
      r_nxt.full = 1'b0;
      r_nxt.nb = 2'h0;
    end
  end

  // State register; every flag protected after reset
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_r <= '0;
      r_r.prot <= PROT_RST;
      r_r.wlat <= LATCH_RST;
      r_r.lock <= LOCK_RST;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  assign sector_prot_out = r_r.prot;
  assign write_enable_latch_out = r_r.wlat;
  assign protection_lock_bit_out = r_r.lock;
  assign pe_allow_out = r_r.allow;

  // Checks on the protection behaviour
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  reset_prot_a: assert property (
    $rose(rst_n) |-> &sector_prot_out
  ) else $error("flags not set after reset");
  pe_gate_a: assert property (
    pe_valid_in && r_r.prot[sector_of(pe_addr_in)] |=> !pe_allow_out
  ) else $error("protected sector allowed");
  prot_set_a: assert property (
    do_prot |=> sector_prot_out[sector_of($past(r_r.addr))] && !write_enable_latch_out
  ) else $error("protect failed");
  abort_keep_a: assert property (
    frame_end && r_r.got && sect_cmd && (!r_r.full || !aligned)
    |=> $stable(sector_prot_out) && !write_enable_latch_out
  ) else $error("abort changed flags");
  lock_prot_a: assert property (
    frame_end && r_r.got && r_r.opc == OPC_PROT && r_r.lock
    |=> $stable(sector_prot_out) && !write_enable_latch_out
  ) else $error("locked protect acted");
  unprot_clr_a: assert property (
    do_unprot |=> !sector_prot_out[sector_of($past(r_r.addr))] && !write_enable_latch_out
  ) else $error("unprotect failed");
  lock_unprot_a: assert property (
    frame_end && r_r.got && r_r.opc == OPC_UNPROT && r_r.lock
    |=> $stable(sector_prot_out) && !write_enable_latch_out
  ) else $error("locked unprotect acted");
  glob_prot_a: assert property (
    do_wsr && !r_r.lock && glob_bits == SR_GLOB_ONES |=> &sector_prot_out
  ) else $error("global protect failed");
  glob_unprot_a: assert property (
    do_wsr && !r_r.lock && glob_bits == SR_GLOB_ZEROS |=> sector_prot_out == '0
  ) else $error("global unprotect failed");
  lock_store_a: assert property (
    do_wsr |=> protection_lock_bit_out == $past(r_r.sr[SR_LOCK_POS])
  ) else $error("lock bit not stored");
  hard_lock_a: assert property (
    hard_lock |=> $stable(sector_prot_out) && $stable(protection_lock_bit_out)
  ) else $error("hard lock broken");
  latch_set_a: assert property (
    frame_end && r_r.got && aligned && r_r.opc == OPC_WREN |=> write_enable_latch_out
  ) else $error("latch not set");
  no_latch_a: assert property (
    frame_end && sect_cmd && !r_r.wlat |=> $stable(sector_prot_out)
  ) else $error("sector command ran without latch");

  prot_seen_c: cover property (do_prot);
  unprot_seen_c: cover property (do_unprot);
  glob_seen_c: cover property (do_wsr && !r_r.lock);
  hard_seen_c: cover property (hard_lock && frame_end);
endmodule : fsp_sector_protect

// ==== fsp_host_model.sv ====
// SPI host model that frames commands into the protection block
`timescale 1ns/1ps
module fsp_host_model
(
  input wire logic clk_in,
  output logic sck_out,
  output logic cs_n_out,
  output logic si_out
);
  // Idle with chip select high and the serial clock parked low
  initial
  begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
  end
  // Shifts n bits MSB first, each clock phase four system cycles long
  task automatic frame(input logic [39:0] bits, input int n);
    int i;
    @(negedge clk_in);
    cs_n_out = 1'b0;
    for (i = 0; i < n; i++)
    begin
      si_out = bits[39-i];
      repeat (4) @(negedge clk_in);
      sck_out = 1'b1;
      repeat (4) @(negedge clk_in);
      sck_out = 1'b0;
    end
    repeat (4) @(negedge clk_in);
    cs_n_out = 1'b1;
    si_out = ~si_out; // Released data line shows no stale bit
    repeat (10) @(negedge clk_in);
  endtask : frame
endmodule : fsp_host_model

// ==== flash_sector_protection_bench.sv ====
// Self-checking bench for the sector protection block
`timescale 1ns/1ps
module flash_sector_protection_bench;
  import fsp_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in, wp_n_in, pe_valid_in;
  logic [23:0] pe_addr_in;
  logic sck, cs_n, si, wlatch, lock, pe_allow;
  logic [3:0] prot, exp_prot;
  logic exp_lock;
  logic [31:0] seed = 32'h5df4c0b9;
  int miscompares = 0;
  int samples_checked = 0;
  // Clock at 40 MHz
  always #12.5 clk_in = ~clk_in;
  fsp_sector_protect uut (.clk_in(clk_in), .resetn_in(resetn_in), .spi_sck_in(sck), .spi_cs_n_in(cs_n),
    .spi_si_in(si), .wp_n_in(wp_n_in), .pe_addr_in(pe_addr_in), .pe_valid_in(pe_valid_in),
    .sector_prot_out(prot), .write_enable_latch_out(wlatch), .protection_lock_bit_out(lock),
    .pe_allow_out(pe_allow));
  fsp_host_model host (.clk_in(clk_in), .sck_out(sck), .cs_n_out(cs_n), .si_out(si));
  // One-hot flag position for an address
  function automatic logic [3:0] sect_mask(input logic [23:0] a);
    return 4'h1 << a[SECT_LSB_DEF +: SECT_IDX_W];
  endfunction : sect_mask
  // Random address inside sector s
  function automatic logic [23:0] rand_addr(input logic [1:0] s);
    logic [23:0] a;
    a = 24'($random(seed));
    a[23:16] = {6'h00, s};
    return a;
  endfunction : rand_addr
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Flags, latch and lock against the bench's own model
  task automatic check_state();
    check(32'(prot), 32'(exp_prot));
    check(32'(wlatch), 32'h0);
    check(32'(lock), 32'(exp_lock));
  endtask : check_state
  task automatic wren();
    host.frame({OPC_WREN, 32'h0}, 8);
    check(32'(wlatch), 32'h1);
  endtask : wren
  task automatic sect_cmd(input logic [7:0] opc, input logic [1:0] s, input int n);
    host.frame({opc, rand_addr(s), 8'h5a}, n);
  endtask : sect_cmd
  task automatic status(input logic [7:0] d);
    host.frame({OPC_WRSR_DEF, d, 24'h0}, 16);
  endtask : status
  // Program and erase queries at random addresses
  task automatic pe_probe();
    int k;
    logic [23:0] a;
    for (k = 0; k < 6; k++)
    begin
      a = rand_addr(2'($random(seed)));
      pe_addr_in = a;
      pe_valid_in = 1'b1;
      @(negedge clk_in);
      @(negedge clk_in);
      check(32'(pe_allow), 32'((exp_prot & sect_mask(a)) == 4'h0));
    end
    pe_valid_in = 1'b0;
    repeat (2) @(negedge clk_in);
    check(32'(pe_allow), 32'h0);
  endtask : pe_probe
  task automatic tally_and_finish();
    if (miscompares == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // Watchdog against a hung handshake
  initial
  begin
    repeat (60000) @(posedge clk_in);
    miscompares++;
    tally_and_finish();
  end
  // Main sequence
  initial
  begin
    resetn_in = 1'b0;
    wp_n_in = 1'b1;
    pe_valid_in = 1'b0;
    pe_addr_in = 24'h0;
    exp_prot = 4'hf;
    exp_lock = 1'b0;
    repeat (16) @(posedge clk_in);
    @(negedge clk_in);
    resetn_in = 1'b1;
    repeat (6) @(negedge clk_in);
    check_state();
    // Write enable cut off a byte boundary leaves the latch clear
    host.frame({OPC_WREN, 32'h0}, 11);
    check(32'(wlatch), 32'h0);
    // Unprotect every sector, odd ones with a trailing byte
    for (int s = 0; s < 4; s++)
    begin
      wren();
      sect_cmd(OPC_UNPROT, 2'(s), 32 + 8 * (s % 2));
      exp_prot &= ~(4'h1 << s);
      check_state();
    end
    sect_cmd(OPC_PROT, 2'h1, 32);
    check_state();
    wren();
    sect_cmd(OPC_PROT, 2'h1, 24);
    check_state();
    wren();
    sect_cmd(OPC_PROT, 2'h1, 35);
    check_state();
    wren();
    sect_cmd(OPC_PROT, 2'h2, 40);
    exp_prot = 4'h4;
    check_state();
    pe_probe();
    // Global protect, global unprotect, then a single sector again
    wren();
    status(8'h3c);
    exp_prot = 4'hf;
    check_state();
    wren();
    status(8'h00);
    exp_prot = 4'h0;
    check_state();
    wren();
    status(8'h14);
    check_state();
    wren();
    sect_cmd(OPC_PROT, 2'h1, 32);
    exp_prot = 4'h2;
    check_state();
    pe_probe();
    // Lock set together with a global unprotect
    wren();
    status(8'h80);
    exp_prot = 4'h0;
    exp_lock = 1'b1;
    check_state();
    wren();
    sect_cmd(OPC_PROT, 2'h0, 32);
    check_state();
    // Pin low with lock set: status write changes neither flags nor lock, only clears the latch
    wp_n_in = 1'b0;
    wren();
    status(8'h3c);
    host.frame({OPC_WRDI, 32'h0}, 8);
    check_state();
    // Pin high: first write clears only the lock bit, second sets it together with a global protect
    wp_n_in = 1'b1;
    wren();
    status(8'h3c);
    exp_lock = 1'b0;
    check_state();
    wren();
    status(8'hbc);
    exp_prot = 4'hf;
    exp_lock = 1'b1;
    check_state();
    wren();
    sect_cmd(OPC_UNPROT, 2'h3, 32);
    check_state();
    tally_and_finish();
  end
endmodule : flash_sector_protection_bench
